// File: verilog/rcn_pkg.sv
package rcn_pkg;
   // register identities on the get/set item space
   localparam logic [15:0] ADDR_VSET = 16'h2001;
   localparam logic [15:0] ADDR_REMOTE_VOLT_INFO = 16'h2002;
   localparam logic [15:0] ADDR_REMOTE_TEMP_INFO = 16'h2003;
   localparam logic [15:0] ADDR_STATE = 16'h200C;
   localparam logic [15:0] ADDR_INFO = 16'h200D;
   localparam logic [15:0] ADDR_MODE = 16'h200E;
   localparam logic [15:0] ADDR_STATUS = 16'h200F;
   localparam logic [15:0] ADDR_ISUM = 16'h2013;
   localparam logic [15:0] ADDR_ILIM = 16'h2015;
   // network control word bit positions
   localparam int MODE_NETWORKED = 0;
   localparam int MODE_SLAVE = 1;
   localparam int MODE_EXTERNAL = 2;
   localparam int MODE_BMS = 3;
   localparam int MODE_INST_MASTER = 5;
   localparam int MODE_STANDBY = 6;
   // reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [15:0] SENSE_RESET = 16'h0000;
   // reserved "no data" values
   localparam logic [15:0] REMOTE_VOLT_INFO_NONE = 16'hFFFF;
   localparam logic [15:0] REMOTE_TEMP_INFO_NONE = 16'h7FFF;
   // voltage window and compensation, units of 0.01 V
   localparam logic signed [16:0] REMOTE_VOLT_INFO_WINDOW = 17'sh001F4;
   localparam logic signed [16:0] COMP_LIMIT = 17'sh000C8;
   // charge state codes
   localparam logic [7:0] ST_NOT_CHARGING = 8'h00;
   localparam logic [7:0] ST_FAULT = 8'h02;
   localparam logic [7:0] ST_FLOAT = 8'h05;
   localparam logic [7:0] ST_STORAGE = 8'h06;
   localparam logic [7:0] ST_POWER_SUPPLY = 8'h0B;
   localparam logic [7:0] ST_REP_ABS = 8'hF6;
   localparam logic [7:0] ST_BATT_SAFE = 8'hF8;
   localparam logic [7:0] ST_LOAD_DETECT = 8'hF9;
   localparam logic [7:0] ST_EXTERNAL = 8'hFC;
   localparam logic [7:0] ST_UNAVAILABLE = 8'hFF;
   // role codes in the status low nibble
   localparam logic [3:0] ROLE_SLAVE = 4'h0;
   localparam logic [3:0] ROLE_INST_MASTER = 4'h2;
   localparam logic [3:0] ROLE_STANDALONE = 4'h4;
   // error code for a lost battery manager
   localparam logic [7:0] ERR_BMS_LOST = 8'h43;
   localparam logic [7:0] ERR_NONE = 8'h00;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SECOND_NS = 1000000000;
   localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
   localparam int EXT_TIMEOUT_S = 60;
   localparam int SENSE_TIMEOUT_S = 60;
   localparam int GRACE_S = 45;
   localparam logic [6:0] EXT_TIMEOUT = 7'(EXT_TIMEOUT_S);
   localparam logic [6:0] SENSE_TIMEOUT = 7'(SENSE_TIMEOUT_S);
   localparam logic [6:0] GRACE_TIME = 7'(GRACE_S);
   localparam logic [6:0] AGE_ZERO = 7'h00;
   // protection sequencer states
   typedef enum logic [2:0] {BP_START, BP_OFF, BP_GRACE, BP_RUN, BP_LOST} rcn_bp_t;
endpackage

// File: verilog/rcn_remote_charge_network_control.sv
`timescale 1ns/1ps
// Behaviour
// - mode bit 0 only blinks networked indicator
// - bits 1/2 remote control; 5 master; 6 standby
// - bit 3 remote setpoints plus manager protection
// - remote voltage setpoint reports state 252
// - current-only keeps internal charge phases reported
// - external control reverts after one silent minute
// - manager voltage-only: estimate state, max current
// - manager current-only: internal voltage sequence used
// - manager bit plus setpoint stores manager-present
// - manager-present and no data: stop, error 67
// - start-up grace: float 45 s, then error
// - remote sensor values expire after 60 s
// - voltage accepted within 5V; compensation 2V
// - network info bits 0..8 as listed
// - status nibble role codes, one interface
// - status bits 4..7 flag sensor info use
// - state register uses documented charge codes
// - master-set states only shown in slave mode
// - summed battery current against tail threshold
// - reserved sensor values mark data unavailable
module rcn_remote_charge_network_control #(
   parameter int SECOND_CYCLES = rcn_pkg::SECOND_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wr_id,
   input wire logic [31:0] reg_wr_data,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rd_id,
   output logic [31:0] reg_rd_data,
   output logic reg_rd_ok,
   input wire logic [7:0] internal_state,
   input wire logic [15:0] internal_vset,
   input wire logic [15:0] terminal_voltage,
   input wire logic [15:0] battery_max_current,
   input wire logic bms_present_stored,
   input wire logic estimated_current_info,
   input wire logic measured_current_info,
   input wire logic [31:0] own_battery_current,
   input wire logic [31:0] other_battery_current,
   input wire logic [31:0] tail_current,
   output logic network_blink,
   output logic standby,
   output logic [15:0] voltage_setpoint,
   output logic [15:0] current_limit,
   output logic soc_from_voltage,
   output logic force_float,
   output logic charge_enable,
   output logic [7:0] error_code,
   output logic bms_present_save,
   output logic remote_volt_info,
   output logic remote_temp_info,
   output logic signed [15:0] volt_compensation,
   output logic [15:0] remote_temperature,
   output logic tail_reached
);
   // ==========================================================
   // one-second timebase
   // ==========================================================
   logic [31:0] sec_cnt_reg; // cycle counter inside one second
   logic [31:0] sec_cnt_next;
   logic tick; // one-cycle pulse each second

   // a single divider feeds every timeout so they all age together
   always_comb begin
      tick = (sec_cnt_reg == 32'(SECOND_CYCLES - 1));
      sec_cnt_next = tick ? 32'h00000000 : sec_cnt_reg + 32'h00000001;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sec_cnt_reg <= 32'h00000000;
      end else begin
         sec_cnt_reg <= sec_cnt_next;
      end
   end

   // ==========================================================
   // write decode and sensor acceptance
   // ==========================================================
   logic wr_vset, wr_ilim, wr_remote_volt_info, wr_remote_temp_info, wr_mode; // per-register writes
   logic signed [16:0] vdiff; // written voltage minus terminal voltage
   logic remote_volt_info_in_window;
   logic [15:0] wdata16;

   always_comb begin
      wdata16 = reg_wr_data[15:0];
      wr_vset = reg_wr && (reg_wr_id == rcn_pkg::ADDR_VSET);
      wr_ilim = reg_wr && (reg_wr_id == rcn_pkg::ADDR_ILIM);
      wr_remote_volt_info = reg_wr && (reg_wr_id == rcn_pkg::ADDR_REMOTE_VOLT_INFO);
      wr_remote_temp_info = reg_wr && (reg_wr_id == rcn_pkg::ADDR_REMOTE_TEMP_INFO);
      wr_mode = reg_wr && (reg_wr_id == rcn_pkg::ADDR_MODE);
      vdiff = $signed({1'b0, wdata16}) - $signed({1'b0, terminal_voltage});
      // far-off readings are wiring faults, not cable drop
      remote_volt_info_in_window = (vdiff <= rcn_pkg::REMOTE_VOLT_INFO_WINDOW) && (vdiff >= -rcn_pkg::REMOTE_VOLT_INFO_WINDOW);
   end

   // ==========================================================
   // remote registers and timeouts
   // ==========================================================
   logic [7:0] mode_reg, mode_next; // network control word
   logic [15:0] vset_reg, vset_next;
   logic [15:0] ilim_reg, ilim_next;
   logic [15:0] remote_volt_info_reg, remote_volt_info_next;
   logic [15:0] remote_temp_info_reg, remote_temp_info_next;
   logic vset_rx_reg, vset_rx_next; // a voltage setpoint has arrived
   logic ilim_rx_reg, ilim_rx_next; // a current limit has arrived
   logic vs_ok_reg, vs_ok_next; // remote voltage usable
   logic ts_ok_reg, ts_ok_next; // remote temperature usable
   logic [6:0] data_age_reg, data_age_next; // seconds since last setpoint
   logic [6:0] vs_age_reg, vs_age_next;
   logic [6:0] ts_age_reg, ts_age_next;
   logic stand_alone; // control word all zero
   logic data_expired;

   // ages saturate at their limit so expiry is a steady level
   always_comb begin
      mode_next = wr_mode ? reg_wr_data[7:0] : mode_reg;
      vset_next = wr_vset ? wdata16 : vset_reg;
      ilim_next = wr_ilim ? wdata16 : ilim_reg;
      remote_volt_info_next = remote_volt_info_reg;
      remote_temp_info_next = remote_temp_info_reg;
      vset_rx_next = vset_rx_reg | wr_vset;
      ilim_rx_next = ilim_rx_reg | wr_ilim;
      vs_ok_next = vs_ok_reg;
      ts_ok_next = ts_ok_reg;
      data_age_next = data_age_reg;
      vs_age_next = vs_age_reg;
      ts_age_next = ts_age_reg;
      if (tick && data_age_reg != rcn_pkg::EXT_TIMEOUT) begin
         data_age_next = data_age_reg + 7'h01;
      end
      if (tick && vs_age_reg != rcn_pkg::SENSE_TIMEOUT) begin
         vs_age_next = vs_age_reg + 7'h01;
      end
      if (tick && ts_age_reg != rcn_pkg::SENSE_TIMEOUT) begin
         ts_age_next = ts_age_reg + 7'h01;
      end
      // silence for the timeout drops the remote value
      if (vs_age_reg == rcn_pkg::SENSE_TIMEOUT) begin
         vs_ok_next = 1'b0;
      end
      if (ts_age_reg == rcn_pkg::SENSE_TIMEOUT) begin
         ts_ok_next = 1'b0;
      end
      if (wr_vset || wr_ilim) begin
         data_age_next = rcn_pkg::AGE_ZERO;
      end
      if (wr_remote_volt_info) begin
         if (wdata16 == rcn_pkg::REMOTE_VOLT_INFO_NONE) begin
            vs_ok_next = 1'b0;
         end else if (remote_volt_info_in_window) begin
            remote_volt_info_next = wdata16;
            vs_ok_next = 1'b1;
            vs_age_next = rcn_pkg::AGE_ZERO;
         end
      end
      if (wr_remote_temp_info) begin
         if (wdata16 == rcn_pkg::REMOTE_TEMP_INFO_NONE) begin
            ts_ok_next = 1'b0;
         end else begin
            remote_temp_info_next = wdata16;
            ts_ok_next = 1'b1;
            ts_age_next = rcn_pkg::AGE_ZERO;
         end
      end
      // expired setpoints are forgotten: next control needs fresh ones
      if (data_age_reg == rcn_pkg::EXT_TIMEOUT) begin
         vset_rx_next = wr_vset;
         ilim_rx_next = wr_ilim;
      end
      // back to stand-alone: setpoint flags and all three ages start over
      // cleared on the write only, so ages keep running while stand-alone and
      // stale sensors or a silent manager still time out
      if (wr_mode && reg_wr_data[7:0] == rcn_pkg::MODE_RESET) begin
         vset_rx_next = 1'b0;
         ilim_rx_next = 1'b0;
         data_age_next = rcn_pkg::AGE_ZERO;
         vs_age_next = rcn_pkg::AGE_ZERO;
         ts_age_next = rcn_pkg::AGE_ZERO;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= rcn_pkg::MODE_RESET;
         vset_reg <= rcn_pkg::SENSE_RESET;
         ilim_reg <= rcn_pkg::SENSE_RESET;
         remote_volt_info_reg <= rcn_pkg::SENSE_RESET;
         remote_temp_info_reg <= rcn_pkg::SENSE_RESET;
         vset_rx_reg <= 1'b0;
         ilim_rx_reg <= 1'b0;
         vs_ok_reg <= 1'b0;
         ts_ok_reg <= 1'b0;
         data_age_reg <= rcn_pkg::AGE_ZERO;
         vs_age_reg <= rcn_pkg::AGE_ZERO;
         ts_age_reg <= rcn_pkg::AGE_ZERO;
      end else begin
         mode_reg <= mode_next;
         vset_reg <= vset_next;
         ilim_reg <= ilim_next;
         remote_volt_info_reg <= remote_volt_info_next;
         remote_temp_info_reg <= remote_temp_info_next;
         vset_rx_reg <= vset_rx_next;
         ilim_rx_reg <= ilim_rx_next;
         vs_ok_reg <= vs_ok_next;
         ts_ok_reg <= ts_ok_next;
         data_age_reg <= data_age_next;
         vs_age_reg <= vs_age_next;
         ts_age_reg <= ts_age_next;
      end
   end

   // ==========================================================
   // manager protection sequencer
   // ==========================================================
   rcn_pkg::rcn_bp_t bp_reg, bp_next;
   logic [6:0] grace_reg, grace_next; // seconds spent in start-up float
   logic save_next;

   // the stored setting is read on the first edge after reset
   always_comb begin
      bp_next = bp_reg;
      grace_next = grace_reg;
      save_next = 1'b0;
      unique case (bp_reg)
         rcn_pkg::BP_START: begin
            bp_next = bms_present_stored ? rcn_pkg::BP_GRACE : rcn_pkg::BP_OFF;
         end
         rcn_pkg::BP_OFF: begin
            if (mode_reg[rcn_pkg::MODE_BMS] && (wr_vset || wr_ilim)) begin
               bp_next = rcn_pkg::BP_RUN;
               save_next = 1'b1;
            end
         end
         rcn_pkg::BP_GRACE: begin
            if (wr_vset || wr_ilim) begin
               bp_next = rcn_pkg::BP_RUN;
            end else if (grace_reg == rcn_pkg::GRACE_TIME) begin
               bp_next = rcn_pkg::BP_LOST;
            end else if (tick) begin
               grace_next = grace_reg + 7'h01;
            end
         end
         rcn_pkg::BP_RUN: begin
            if (data_expired && !(wr_vset || wr_ilim)) begin
               bp_next = rcn_pkg::BP_LOST;
            end
         end
         rcn_pkg::BP_LOST: begin
            if (wr_vset || wr_ilim) begin
               bp_next = rcn_pkg::BP_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bp_reg <= rcn_pkg::BP_START;
         grace_reg <= rcn_pkg::AGE_ZERO;
         bms_present_save <= 1'b0;
      end else begin
         bp_reg <= bp_next;
         grace_reg <= grace_next;
         bms_present_save <= save_next;
      end
   end

   // ==========================================================
   // control outputs and reported state
   // ==========================================================
   logic slave_mode, remote_ctl, vset_active, ilim_active, bms_mode;
   logic slave_only_state;
   logic [7:0] state_shown;
   logic [31:0] isum;
   logic [15:0] info_word;
   logic [7:0] status_word;
   logic [3:0] role;
   logic signed [16:0] comp_raw;

   always_comb begin
      stand_alone = (mode_reg == rcn_pkg::MODE_RESET);
      data_expired = (data_age_reg == rcn_pkg::EXT_TIMEOUT);
      bms_mode = mode_reg[rcn_pkg::MODE_BMS];
      slave_mode = mode_reg[rcn_pkg::MODE_SLAVE] | mode_reg[rcn_pkg::MODE_EXTERNAL] | bms_mode;
      remote_ctl = slave_mode && !data_expired;
      vset_active = remote_ctl && vset_rx_reg;
      ilim_active = remote_ctl && ilim_rx_reg;
      network_blink = mode_reg[rcn_pkg::MODE_NETWORKED];
      standby = mode_reg[rcn_pkg::MODE_STANDBY];
      voltage_setpoint = vset_active ? vset_reg : internal_vset;
      // remote limit never exceeds the battery maximum
      if (ilim_active && (ilim_reg < battery_max_current)) begin
         current_limit = ilim_reg;
      end else begin
         current_limit = battery_max_current;
      end
      soc_from_voltage = bms_mode && vset_active && !ilim_active;
      force_float = (bp_reg == rcn_pkg::BP_GRACE);
      charge_enable = (bp_reg != rcn_pkg::BP_LOST);
      error_code = (bp_reg == rcn_pkg::BP_LOST) ? rcn_pkg::ERR_BMS_LOST : rcn_pkg::ERR_NONE;
      remote_volt_info = vs_ok_reg;
      remote_temp_info = ts_ok_reg;
      remote_temperature = remote_temp_info_reg;
      comp_raw = $signed({1'b0, remote_volt_info_reg}) - $signed({1'b0, terminal_voltage});
      // cable drop compensation is clamped, a bad sensor cannot run away
      if (!vs_ok_reg) begin
         volt_compensation = 16'sh0000;
      end else if (comp_raw > rcn_pkg::COMP_LIMIT) begin
         volt_compensation = 16'(rcn_pkg::COMP_LIMIT);
      end else if (comp_raw < -rcn_pkg::COMP_LIMIT) begin
         volt_compensation = 16'(-rcn_pkg::COMP_LIMIT);
      end else begin
         volt_compensation = comp_raw[15:0];
      end
      isum = own_battery_current + other_battery_current;
      tail_reached = ($signed(isum) <= $signed(tail_current));
      slave_only_state = (internal_state == rcn_pkg::ST_STORAGE) || (internal_state == rcn_pkg::ST_POWER_SUPPLY) ||
                         (internal_state == rcn_pkg::ST_REP_ABS) || (internal_state == rcn_pkg::ST_BATT_SAFE) ||
                         (internal_state == rcn_pkg::ST_LOAD_DETECT) || (internal_state == rcn_pkg::ST_EXTERNAL);
      // priority: lost manager, grace float, remote voltage, internal phase
      if (bp_reg == rcn_pkg::BP_LOST) begin
         state_shown = rcn_pkg::ST_NOT_CHARGING;
      end else if (bp_reg == rcn_pkg::BP_GRACE) begin
         state_shown = rcn_pkg::ST_FLOAT;
      end else if (vset_active) begin
         state_shown = rcn_pkg::ST_EXTERNAL;
      end else if (slave_only_state && !slave_mode) begin
         state_shown = rcn_pkg::ST_UNAVAILABLE;
      end else begin
         state_shown = internal_state;
      end
      // only one interface here, so status is its own copy
      if (slave_mode) begin
         role = rcn_pkg::ROLE_SLAVE;
      end else if (mode_reg[rcn_pkg::MODE_INST_MASTER]) begin
         role = rcn_pkg::ROLE_INST_MASTER;
      end else begin
         role = rcn_pkg::ROLE_STANDALONE;
      end
      info_word = {7'h00, standby, vs_ok_reg, ts_ok_reg, measured_current_info, estimated_current_info,
                   mode_reg[rcn_pkg::MODE_INST_MASTER], slave_mode, vset_active, bms_mode};
      status_word = {vs_ok_reg, ts_ok_reg, measured_current_info, estimated_current_info, role};
   end

   // ==========================================================
   // read port
   // ==========================================================
   logic [31:0] rd_next;
   logic rd_ok_next;

   // unknown identities answer zero with ok low; data holds between reads
   always_comb begin
      rd_next = reg_rd_data;
      rd_ok_next = reg_rd;
      if (reg_rd) begin
         rd_next = 32'h00000000;
         unique case (reg_rd_id)
            rcn_pkg::ADDR_VSET: rd_next = {16'h0000, vset_reg};
            rcn_pkg::ADDR_REMOTE_VOLT_INFO: rd_next = {16'h0000, vs_ok_reg ? remote_volt_info_reg : rcn_pkg::REMOTE_VOLT_INFO_NONE};
            rcn_pkg::ADDR_REMOTE_TEMP_INFO: rd_next = {16'h0000, ts_ok_reg ? remote_temp_info_reg : rcn_pkg::REMOTE_TEMP_INFO_NONE};
            rcn_pkg::ADDR_STATE: rd_next = {24'h000000, state_shown};
            rcn_pkg::ADDR_INFO: rd_next = {16'h0000, info_word};
            rcn_pkg::ADDR_MODE: rd_next = {24'h000000, mode_reg};
            rcn_pkg::ADDR_STATUS: rd_next = {24'h000000, status_word};
            rcn_pkg::ADDR_ISUM: rd_next = isum;
            rcn_pkg::ADDR_ILIM: rd_next = {16'h0000, ilim_reg};
            default: rd_ok_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rd_data <= 32'h00000000;
         reg_rd_ok <= 1'b0;
      end else begin
         reg_rd_data <= rd_next;
         reg_rd_ok <= rd_ok_next;
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   sequence vset_write_s;
      wr_vset && mode_reg[rcn_pkg::MODE_EXTERNAL] && !mode_next[rcn_pkg::MODE_BMS] && bp_reg == rcn_pkg::BP_OFF;
   endsequence
   sequence state_read_s;
      reg_rd && reg_rd_id == rcn_pkg::ADDR_STATE;
   endsequence

   ext_state_a: assert property (@(posedge clk) disable iff (!rstn)
      vset_write_s ##1 !reg_wr ##1 state_read_s |=> reg_rd_data[7:0] == rcn_pkg::ST_EXTERNAL)
      else $error("remote setpoint not shown as external control");
   revert_timeout_a: assert property (@(posedge clk) disable iff (!rstn)
      data_age_reg == rcn_pkg::EXT_TIMEOUT |-> voltage_setpoint == internal_vset)
      else $error("remote setpoint used after timeout");
   mgr_save_a: assert property (@(posedge clk) disable iff (!rstn)
      bp_reg == rcn_pkg::BP_OFF && mode_reg[rcn_pkg::MODE_BMS] && wr_ilim |=> bms_present_save ##1 !bms_present_save)
      else $error("manager-present not saved once");
   mgr_lost_a: assert property (@(posedge clk) disable iff (!rstn)
      bp_reg == rcn_pkg::BP_RUN && data_expired && !wr_vset && !wr_ilim |=>
      !charge_enable && error_code == rcn_pkg::ERR_BMS_LOST)
      else $error("lost manager did not stop charging");
   grace_end_a: assert property (@(posedge clk) disable iff (!rstn)
      bp_reg == rcn_pkg::BP_GRACE && grace_reg == rcn_pkg::GRACE_TIME && !wr_vset && !wr_ilim |=>
      bp_reg == rcn_pkg::BP_LOST && !force_float)
      else $error("grace float did not end in error");
   sense_expire_a: assert property (@(posedge clk) disable iff (!rstn)
      vs_age_reg == rcn_pkg::SENSE_TIMEOUT && !wr_remote_volt_info |=> !remote_volt_info)
      else $error("stale remote voltage still used");
   window_reject_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_remote_volt_info && !remote_volt_info_in_window && wdata16 != rcn_pkg::REMOTE_VOLT_INFO_NONE |=> $stable(remote_volt_info_reg))
      else $error("out of window voltage accepted");
   reserved_val_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_remote_temp_info && wdata16 == rcn_pkg::REMOTE_TEMP_INFO_NONE |=> !remote_temp_info)
      else $error("reserved temperature not honoured");
   standalone_clr_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_mode && reg_wr_data[7:0] == rcn_pkg::MODE_RESET |=> data_age_reg == rcn_pkg::AGE_ZERO && !vset_rx_reg)
      else $error("stand-alone did not clear timeouts");
   role_code_a: assert property (@(posedge clk) disable iff (!rstn)
      stand_alone |-> status_word[3:0] == rcn_pkg::ROLE_STANDALONE && network_blink == 1'b0)
      else $error("stand-alone role code wrong");
endmodule

// File: tb/rcn_master_model.sv
`timescale 1ns/1ps
// ====================
// remote controller: single-cycle register writes
module rcn_master_model (
   input wire logic clk,
   output logic reg_wr,
   output logic [15:0] reg_wr_id,
   output logic [31:0] reg_wr_data
);
   initial begin
      reg_wr = 1'b0;
      reg_wr_id = 16'h0000;
      reg_wr_data = 32'h00000000;
   end
   // drive on the falling edge, hold over one rising edge, then scramble the idle bus
   task automatic write(input logic [15:0] id, input logic [31:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_wr_id = id;
      reg_wr_data = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wr_id = ~id;
      reg_wr_data = ~d;
   endtask
endmodule

// File: tb/rcn_remote_charge_network_control_test.sv
`timescale 1ns/1ps
// ====================
// bench: drives on falling edges, compares against integer expectations
module rcn_remote_charge_network_control_test;
   localparam int SC = 10; // short tick so a minute is 600 cycles
   logic clk = 1'b0, rstn = 1'b0, reg_rd = 1'b0, bms = 1'b0, est = 1'b0, meas = 1'b0;
   logic reg_wr, reg_rd_ok, blink, stby, socv, ffl, chg, save, rvi, rti, tail_reached;
   logic [15:0] reg_wr_id, reg_rd_id = 16'h0000, ivset = 16'h0550, term = 16'h04B0, imax = 16'h01F4;
   logic [15:0] vset, ilim, rtemp, v, l, t;
   logic signed [15:0] comp;
   logic [7:0] istate = 8'h03, err;
   logic [31:0] reg_wr_data, reg_rd_data, own = 0, oth = 0, tail = 0;
   int bad_count = 0, n_tests = 0, seed = 32'hd47778a8;
   initial forever #4 clk = ~clk;
   rcn_master_model mm (.clk(clk), .reg_wr(reg_wr), .reg_wr_id(reg_wr_id), .reg_wr_data(reg_wr_data));
   rcn_remote_charge_network_control #(.SECOND_CYCLES(SC)) dut_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
      .reg_wr_id(reg_wr_id), .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .reg_rd_id(reg_rd_id),
      .reg_rd_data(reg_rd_data), .reg_rd_ok(reg_rd_ok), .internal_state(istate), .internal_vset(ivset),
      .terminal_voltage(term), .battery_max_current(imax), .bms_present_stored(bms),
      .estimated_current_info(est), .measured_current_info(meas), .own_battery_current(own),
      .other_battery_current(oth), .tail_current(tail), .network_blink(blink), .standby(stby),
      .voltage_setpoint(vset), .current_limit(ilim), .soc_from_voltage(socv), .force_float(ffl),
      .charge_enable(chg), .error_code(err), .bms_present_save(save), .remote_volt_info(rvi),
      .remote_temp_info(rti), .volt_compensation(comp), .remote_temperature(rtemp), .tail_reached(tail_reached));
   // one compare for every result
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // read strobe held over the taking edge; answer is settled by the next falling edge
   task automatic rd_chk(input logic [15:0] id, input logic [31:0] exp, input logic ok);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_rd_id = id;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_rd_id = ~id;
      cmp({reg_rd_ok, reg_rd_data}, {ok, exp});
   endtask
   task automatic final_report();
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog: the run needs about 1800 cycles
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      final_report();
   end
   initial begin
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      rd_chk(rcn_pkg::ADDR_MODE, 0, 1);
      rd_chk(rcn_pkg::ADDR_STATUS, {28'h0, rcn_pkg::ROLE_STANDALONE}, 1);
      rd_chk(16'h2000, 0, 0); // unmapped id answers nothing
      mm.write(rcn_pkg::ADDR_MODE, 32'h05);
      @(negedge clk);
      cmp(blink, 1);
      l = 16'($random(seed)) & 16'h03FF;
      mm.write(rcn_pkg::ADDR_ILIM, l);
      cmp(ilim, (l < imax) ? l : imax);
      rd_chk(rcn_pkg::ADDR_STATE, istate, 1);
      v = 16'($random(seed)) & 16'h0FFF;
      mm.write(rcn_pkg::ADDR_VSET, v);
      cmp(vset, v);
      rd_chk(rcn_pkg::ADDR_STATE, rcn_pkg::ST_EXTERNAL, 1);
      rd_chk(rcn_pkg::ADDR_INFO, 32'h6, 1);
      mm.write(rcn_pkg::ADDR_REMOTE_VOLT_INFO, term + 16'd600);
      rd_chk(rcn_pkg::ADDR_REMOTE_VOLT_INFO, 32'hFFFF, 1);
      mm.write(rcn_pkg::ADDR_REMOTE_VOLT_INFO, term + 16'd100);
      rd_chk(rcn_pkg::ADDR_REMOTE_VOLT_INFO, term + 16'd100, 1);
      mm.write(rcn_pkg::ADDR_REMOTE_VOLT_INFO, 32'hFFFF);
      rd_chk(rcn_pkg::ADDR_REMOTE_VOLT_INFO, 32'hFFFF, 1);
      own = $random(seed) & 32'hFFFF;
      oth = $random(seed) & 32'hFFFF;
      tail = own + oth;
      rd_chk(rcn_pkg::ADDR_ISUM, own + oth, 1);
      cmp(tail_reached, 1);
      tail = own + oth - 1;
      @(negedge clk);
      cmp(tail_reached, 0);
      // silence beyond one minute of ticks hands control back
      repeat (62 * SC) @(negedge clk);
      cmp(vset, ivset);
      rd_chk(rcn_pkg::ADDR_STATE, istate, 1);
      // manager control: current limit only, sensors, then silence
      mm.write(rcn_pkg::ADDR_MODE, 32'h09);
      mm.write(rcn_pkg::ADDR_ILIM, l);
      cmp(save, 1);
      cmp(vset, ivset);
      cmp(ilim, (l < imax) ? l : imax);
      t = 16'($random(seed)) & 16'h0FFF;
      mm.write(rcn_pkg::ADDR_REMOTE_TEMP_INFO, t);
      mm.write(rcn_pkg::ADDR_REMOTE_VOLT_INFO, term + 16'd300);
      est = 1'b1;
      meas = 1'b1;
      cmp(rtemp, t);
      cmp(comp, 16'h00C8);
      rd_chk(rcn_pkg::ADDR_INFO, 32'hF5, 1);
      rd_chk(rcn_pkg::ADDR_STATUS, 32'hF0, 1);
      mm.write(rcn_pkg::ADDR_REMOTE_TEMP_INFO, 32'h7FFF);
      cmp(rti, 0);
      repeat (62 * SC) @(negedge clk);
      cmp({chg, err}, {1'b0, rcn_pkg::ERR_BMS_LOST});
      cmp({rvi, rti}, 2'b00);
      rd_chk(rcn_pkg::ADDR_STATE, rcn_pkg::ST_NOT_CHARGING, 1);
      // voltage only: state from voltage, limit from battery maximum
      mm.write(rcn_pkg::ADDR_VSET, v);
      cmp({chg, socv, ilim}, {1'b1, 1'b1, imax});
      mm.write(rcn_pkg::ADDR_MODE, 32'h60);
      cmp(stby, 1);
      rd_chk(rcn_pkg::ADDR_INFO, 32'h138, 1);
      rd_chk(rcn_pkg::ADDR_STATUS, 32'h32, 1);
      mm.write(rcn_pkg::ADDR_MODE, 32'h00);
      rd_chk(rcn_pkg::ADDR_STATUS, 32'h34, 1);
      // restart with the manager setting stored: float grace, then give up
      bms = 1'b1;
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      cmp(ffl, 1);
      rd_chk(rcn_pkg::ADDR_STATE, rcn_pkg::ST_FLOAT, 1);
      repeat (47 * SC) @(negedge clk);
      cmp({ffl, chg, err}, {2'b00, rcn_pkg::ERR_BMS_LOST});
      final_report();
   end
endmodule
